/* logic/rips_pkg.sv */
// Constants, register map and carrier types for the reference input priority select block.
// Assumes a single pclk domain with asynchronous active-low reset and an APB register port.
// Function
// - each of four inputs has a two-bit rank, 00 lowest and 11 highest
// - equal ranks are broken in favour of the lower-numbered input, except on revert, which needs a strictly higher rank
// - prescaler select gives activity monitor divide by one or by four
// - revert disabled means a revalidated spare input never replaces a selected input that is still valid
// - revert enable is ignored unless the policy low bit is set
// - revert enable reads as cleared after reset
// - policy codes are 00 manual, 01 auto, 10 short holdover, 11 auto holdover
// - automatic policies select from loss states and ranks, not the manual field
// - manual policies take the input straight from the manual select field
package rips_pkg;

  localparam int RIPS_NREF = 4;
  localparam int RIPS_EV_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0] RIPS_IDX_PRIO = 8'h14;
  localparam logic [7:0] RIPS_IDX_CTRL = 8'h15;
  localparam logic [7:0] RIPS_IDX_HOLD = 8'h16;
  localparam logic [7:0] RIPS_IDX_MON = 8'h17;
  localparam logic [7:0] RIPS_IDX_STAT = 8'h18;
  localparam logic [7:0] RIPS_IDX_IRQ_STAT = 8'h19;
  localparam logic [7:0] RIPS_IDX_IRQ_CLR = 8'h1A;
  localparam logic [7:0] RIPS_IDX_IRQ_EN = 8'h1B;

  localparam logic [11:0] RIPS_ADDR_PRIO = {2'h0, RIPS_IDX_PRIO, 2'h0};
  localparam logic [11:0] RIPS_ADDR_CTRL = {2'h0, RIPS_IDX_CTRL, 2'h0};
  localparam logic [11:0] RIPS_ADDR_HOLD = {2'h0, RIPS_IDX_HOLD, 2'h0};
  localparam logic [11:0] RIPS_ADDR_MON = {2'h0, RIPS_IDX_MON, 2'h0};
  localparam logic [11:0] RIPS_ADDR_STAT = {2'h0, RIPS_IDX_STAT, 2'h0};
  localparam logic [11:0] RIPS_ADDR_IRQ_STAT = {2'h0, RIPS_IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] RIPS_ADDR_IRQ_CLR = {2'h0, RIPS_IDX_IRQ_CLR, 2'h0};
  localparam logic [11:0] RIPS_ADDR_IRQ_EN = {2'h0, RIPS_IDX_IRQ_EN, 2'h0};

  // Reset values
  localparam logic [7:0] RIPS_RST_PRIO = 8'hE4;
  localparam logic [7:0] RIPS_RST_CTRL = 8'h00;
  localparam logic [7:0] RIPS_RST_HOLD = 8'h80;
  localparam logic [7:0] RIPS_RST_MON = 8'h80;
  localparam logic [7:0] RIPS_RST_IRQ_EN = 8'h00;

  // Selection policy codes
  localparam logic [1:0] RIPS_POL_MANUAL = 2'h0;
  localparam logic [1:0] RIPS_POL_AUTO = 2'h1;
  localparam logic [1:0] RIPS_POL_HOLD_SHORT = 2'h2;
  localparam logic [1:0] RIPS_POL_AUTO_HOLD = 2'h3;

  // Interrupt event bit positions
  localparam int RIPS_EV_SWITCH = 0;
  localparam int RIPS_EV_LOSS = 1;
  localparam int RIPS_EV_REVAL = 2;
  localparam int RIPS_EV_NOREF = 3;

  // Control register; reserved bit 7 reads zero
  typedef struct packed {
    logic rsvd;
    logic ref_loss_block;
    logic monitor_prediv_sel;
    logic revert_enable;
    logic [1:0] select_policy;
    logic [1:0] manual_select;
  } rips_ctrl_t;

  typedef struct packed {
    logic [1:0] holdoff_ref_divider;
    logic [3:0] ref_in_powerdown;
    logic [1:0] activity_window_count;
  } rips_mon_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } rips_apb_req_t;

  typedef enum logic [0:0] {
    RIPS_ST_MANUAL,
    RIPS_ST_AUTO
  } rips_state_t;

endpackage

/* logic/rips_top.sv */
// Reference input priority select: APB registers, loss-flag synchronisers, selection FSM, interrupt.
// Assumes loss flags arrive asynchronously from the input monitors and pclk runs at 125 MHz.
`timescale 1ns/1ps
module rips_top
  import rips_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ref_loss_flag,
  output logic [1:0] ref_select,
  output logic monitor_prediv_sel,
  output logic ref_loss_block,
  output logic [7:0] holdoff_period,
  output logic [1:0] holdoff_ref_divider,
  output logic [1:0] activity_window_count,
  output logic [3:0] ref_in_powerdown,
  output logic irq
);

  // Rank code of one input from the priority map; input 0 sits in the top bits
  function automatic logic [1:0] rank_of(input logic [7:0] map, input logic [1:0] idx);
    case (idx)
      2'h0: rank_of = map[7:6];
      2'h1: rank_of = map[5:4];
      2'h2: rank_of = map[3:2];
      default: rank_of = map[1:0];
    endcase
  endfunction

  // Rank in the high bits, inverted index below it so input 0 wins ties
  function automatic logic [3:0] score_of(input logic [7:0] map, input logic [1:0] idx);
    score_of = {rank_of(map, idx), ~idx};
  endfunction

  // Best input of a candidate mask: {found, index}
  function automatic logic [2:0] best_of(input logic [3:0] mask, input logic [7:0] map);
    logic found;
    logic [1:0] idx;
    logic [3:0] best;
    found = 1'b0;
    idx = 2'h0;
    best = 4'h0;
    for (int i = 0; i < RIPS_NREF; i++) begin
      if (mask[i] && (!found || score_of(map, 2'(i)) > best)) begin
        found = 1'b1;
        idx = 2'(i);
        best = score_of(map, 2'(i));
      end
    end
    best_of = {found, idx};
  endfunction

  rips_apb_req_t req;
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata, pstrb: pstrb};

  logic [7:0] prio_ff;
  rips_ctrl_t ctrl_ff;
  logic [7:0] hold_ff;
  rips_mon_t mon_ff;
  logic [RIPS_EV_W-1:0] irq_stat_ff;
  logic [RIPS_EV_W-1:0] irq_en_ff;
  logic irq_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [3:0] loss_meta_ff;
  logic [3:0] loss_sync_ff;
  logic [3:0] loss_prev_ff;
  logic [1:0] sel_ff;
  rips_state_t state_ff;

  logic [1:0] nxt_sel;
  rips_state_t nxt_state;
  logic [RIPS_EV_W-1:0] nxt_irq_stat;

  logic access;
  logic done;
  logic wr_done;
  logic mapped;
  logic [31:0] rd_word;
  logic [3:0] valid;
  logic [3:0] spare;
  logic [3:0] reval;
  logic auto_mode;
  logic [2:0] cand;
  logic [2:0] rv;
  logic [RIPS_EV_W-1:0] events;

  // APB slave: one wait state so that read data and ready come straight from flops
  assign access = req.psel && req.penable;
  assign done = access && pready_ff;
  assign wr_done = done && req.pwrite && req.pstrb[0];

  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0000_0000;
    case (req.paddr)
      RIPS_ADDR_PRIO: rd_word = {24'h00_0000, prio_ff};
      RIPS_ADDR_CTRL: rd_word = {24'h00_0000, ctrl_ff};
      RIPS_ADDR_HOLD: rd_word = {24'h00_0000, hold_ff};
      RIPS_ADDR_MON: rd_word = {24'h00_0000, mon_ff};
      RIPS_ADDR_STAT: rd_word = {25'h000_0000, state_ff == RIPS_ST_AUTO, sel_ff, loss_sync_ff};
      RIPS_ADDR_IRQ_STAT: rd_word = {28'h000_0000, irq_stat_ff};
      RIPS_ADDR_IRQ_CLR: rd_word = 32'h0000_0000;
      RIPS_ADDR_IRQ_EN: rd_word = {28'h000_0000, irq_en_ff};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= access && !pready_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (access && !pready_ff) begin
      prdata_ff <= req.pwrite ? 32'h0000_0000 : rd_word;
      pslverr_ff <= !mapped;
    end else begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_ff <= RIPS_RST_PRIO;
    end else if (wr_done && req.paddr == RIPS_ADDR_PRIO) begin
      prio_ff <= req.pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= RIPS_RST_CTRL;
    end else if (wr_done && req.paddr == RIPS_ADDR_CTRL) begin
      ctrl_ff <= {1'b0, req.pwdata[6:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= RIPS_RST_HOLD;
    end else if (wr_done && req.paddr == RIPS_ADDR_HOLD) begin
      hold_ff <= req.pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_ff <= RIPS_RST_MON;
    end else if (wr_done && req.paddr == RIPS_ADDR_MON) begin
      mon_ff <= req.pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_ff <= RIPS_RST_IRQ_EN[RIPS_EV_W-1:0];
    end else if (wr_done && req.paddr == RIPS_ADDR_IRQ_EN) begin
      irq_en_ff <= req.pwdata[RIPS_EV_W-1:0];
    end
  end

  // Loss flags come from other clocks; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loss_meta_ff <= 4'hF;
      loss_sync_ff <= 4'hF;
      loss_prev_ff <= 4'hF;
    end else begin
      loss_meta_ff <= ref_loss_flag;
      loss_sync_ff <= loss_meta_ff;
      loss_prev_ff <= loss_sync_ff;
    end
  end

  assign valid = ~loss_sync_ff;
  assign spare = ~(4'h1 << sel_ff);
  // An unselected input whose loss flag has just dropped
  assign reval = loss_prev_ff & ~loss_sync_ff & spare;
  // Policies 00 and 10 are manual; revert only matters when the low bit is set
  assign auto_mode = ctrl_ff.select_policy[0];
  assign cand = best_of(valid, prio_ff);
  assign rv = best_of(reval, prio_ff);

  // Selection state machine
  always_comb begin
    nxt_sel = sel_ff;
    nxt_state = state_ff;
    case (state_ff)
      RIPS_ST_MANUAL: begin
        nxt_sel = ctrl_ff.manual_select;
        if (auto_mode) begin
          nxt_state = RIPS_ST_AUTO;
          nxt_sel = sel_ff;
          if (cand[2]) begin
            nxt_sel = cand[1:0];
          end
        end
      end
      RIPS_ST_AUTO: begin
        if (!auto_mode) begin
          nxt_state = RIPS_ST_MANUAL;
          nxt_sel = ctrl_ff.manual_select;
        end else if (!valid[sel_ff]) begin
          // Nothing valid: stay put rather than chase a dead input
          if (cand[2]) begin
            nxt_sel = cand[1:0];
          end
        end else if (ctrl_ff.revert_enable && rv[2]) begin
          if (rank_of(prio_ff, rv[1:0]) > rank_of(prio_ff, sel_ff)) begin
            nxt_sel = rv[1:0];
          end
        end
      end
      default: begin
        nxt_state = RIPS_ST_MANUAL;
        nxt_sel = ctrl_ff.manual_select;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RIPS_ST_MANUAL;
      sel_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      sel_ff <= nxt_sel;
    end
  end

  // Interrupt events; set wins over a clear in the same cycle
  always_comb begin
    events = '0;
    events[RIPS_EV_SWITCH] = nxt_sel != sel_ff;
    events[RIPS_EV_LOSS] = |(loss_sync_ff & ~loss_prev_ff);
    events[RIPS_EV_REVAL] = |(loss_prev_ff & ~loss_sync_ff);
    events[RIPS_EV_NOREF] = auto_mode && (loss_sync_ff == 4'hF) && (loss_prev_ff != 4'hF);
  end

  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_done && req.paddr == RIPS_ADDR_IRQ_CLR) begin
      nxt_irq_stat = nxt_irq_stat & ~req.pwdata[RIPS_EV_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_en_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign ref_select = sel_ff;
  // Monitor prescale: divide by four advised above 250 MHz inputs
  assign monitor_prediv_sel = ctrl_ff.monitor_prediv_sel;
  assign ref_loss_block = ctrl_ff.ref_loss_block;
  assign holdoff_period = hold_ff;
  assign holdoff_ref_divider = mon_ff.holdoff_ref_divider;
  assign activity_window_count = mon_ff.activity_window_count;
  assign ref_in_powerdown = mon_ff.ref_in_powerdown;
  assign irq = irq_ff;

endmodule

/* verif/rips_top_sva.sv */
// Checker for rips_top: APB timing, config stability and selection causes.
// Assumes binding to rips_top and a view of its ports only.
`timescale 1ns/1ps
module rips_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] ref_loss_flag,
  input wire logic [1:0] ref_select,
  input wire logic monitor_prediv_sel,
  input wire logic [7:0] holdoff_period,
  input wire logic [3:0] ref_in_powerdown,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_done = psel && penable && pwrite && pready;
  wire logic [12:0] cfg = {monitor_prediv_sel, holdoff_period, ref_in_powerdown};

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  unmapped_err_a: assert property (pready |-> pslverr == (paddr < 12'h050 || paddr > 12'h06C || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address map");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read completion");
  cfg_stable_a: assert property (!wr_done |=> $stable(cfg))
    else $error("config output changed without a write");
  reset_values_a: assert property ($rose(presetn) |-> cfg == 13'h0800 && ref_select == 2'h0)
    else $error("outputs not at reset values");
  select_cause_a: assert property ($changed(ref_select) |-> $past(wr_done) || $past(wr_done, 2) ||
    $past(ref_loss_flag, 2) != $past(ref_loss_flag, 3) || $past(ref_loss_flag, 3) != $past(ref_loss_flag, 4))
    else $error("selection changed without cause");

  cover property (pready && pslverr);
  cover property ($changed(ref_select));
  cover property ($rose(irq));
endmodule

bind rips_top rips_top_sva i_rips_top_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ref_loss_flag(ref_loss_flag), .ref_select(ref_select), .monitor_prediv_sel(monitor_prediv_sel),
  .holdoff_period(holdoff_period), .ref_in_powerdown(ref_in_powerdown), .irq(irq));

/* verif/rips_ref_src.sv */
// Model of the four reference sources as seen through their loss monitors.
// Assumes the bench asks for failures; flags move just after a clock edge.
`timescale 1ns/1ps
module rips_ref_src (
  input wire logic pclk,
  input wire logic [3:0] fail_req,
  output logic [3:0] ref_loss_flag
);
  // Real sources fail without regard to pclk; one edge of delay is enough here
  always_ff @(posedge pclk) begin
    ref_loss_flag <= fail_req;
  end
endmodule

/* verif/tb_top.sv */
// Bench for rips_top: APB register tests, manual and automatic selection, interrupt.
// Assumes the reference source model in rips_ref_src.
`timescale 1ns/1ps
module tb_top;
  import rips_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, prediv, lblk, irq;
  logic [3:0] fail_req = 4'h0;
  logic [3:0] pstrb = 4'hF;
  logic [3:0] loss, pdn;
  logic [1:0] sel, hdiv, awin;
  logic [7:0] hold;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int n_checks = 0;

  initial forever #4 pclk = ~pclk;

  rips_ref_src i_rips_ref_src (.pclk(pclk), .fail_req(fail_req), .ref_loss_flag(loss));
  rips_top i_rips_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_loss_flag(loss), .ref_select(sel), .monitor_prediv_sel(prediv), .ref_loss_block(lblk),
    .holdoff_period(hold), .holdoff_ref_divider(hdiv), .activity_window_count(awin),
    .ref_in_powerdown(pdn), .irq(irq));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One wait state: ready in the second access cycle
    chk("pready wait", 32'h2, n);
  endtask

  task automatic step(input logic [3:0] f, input logic [1:0] exp);
    @(posedge pclk);
    fail_req <= f;
    repeat (8) @(posedge pclk);
    chk("ref_select", {30'h0, exp}, {30'h0, sel});
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, RIPS_ADDR_CTRL, 8'h0);
    chk("ctrl reset", {24'h0, RIPS_RST_CTRL}, rd);
    apb(1'b0, RIPS_ADDR_PRIO, 8'h0);
    chk("prio reset", 32'h000000E4, rd);
    apb(1'b0, 12'h0FC, 8'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, RIPS_ADDR_HOLD, 8'h0);
    chk("hold reset", {24'h0, RIPS_RST_HOLD}, rd);
    apb(1'b0, RIPS_ADDR_MON, 8'h0);
    chk("mon reset", {24'h0, RIPS_RST_MON}, rd);
    apb(1'b1, RIPS_ADDR_HOLD, 8'h5A);
    // Low byte strobe clear: write must be dropped
    pstrb <= 4'h0;
    apb(1'b1, RIPS_ADDR_HOLD, 8'h11);
    pstrb <= 4'hF;
    apb(1'b0, RIPS_ADDR_HOLD, 8'h0);
    chk("hold masked write", 32'h5A, rd);
    chk("holdoff_period", 32'h5A, {24'h0, hold});
    apb(1'b1, RIPS_ADDR_MON, 8'hB6);
    apb(1'b0, RIPS_ADDR_MON, 8'h0);
    chk("mon", 32'hB6, rd);
    chk("holdoff_ref_divider", 32'h2, {30'h0, hdiv});
    chk("ref_in_powerdown", 32'hD, {28'h0, pdn});
    chk("activity_window_count", 32'h2, {30'h0, awin});
    apb(1'b1, RIPS_ADDR_CTRL, 8'hC0);
    apb(1'b0, RIPS_ADDR_CTRL, 8'h0);
    chk("ctrl reserved", 32'h40, rd);
    chk("ref_loss_block", 32'h1, {31'h0, lblk});
    // Auto codes ignore the manual field; all valid so input 0 wins
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) begin
        apb(1'b1, RIPS_ADDR_CTRL, {4'h0, p[1:0], s[1:0]});
        step(4'h0, p[0] ? 2'h0 : s[1:0]);
      end
    end
    apb(1'b1, RIPS_ADDR_CTRL, 8'h20);
    step(4'h0, 2'h0);
    chk("prediv", 32'h1, {31'h0, prediv});
    apb(1'b1, RIPS_ADDR_CTRL, 8'h07);
    step(4'h0, 2'h0);
    step(4'h1, 2'h1);
    step(4'h0, 2'h1);
    apb(1'b1, RIPS_ADDR_CTRL, 8'h13);
    step(4'h1, 2'h3);
    step(4'h0, 2'h3);
    apb(1'b1, RIPS_ADDR_CTRL, 8'h1C);
    step(4'h1, 2'h1);
    step(4'h0, 2'h0);
    apb(1'b1, RIPS_ADDR_PRIO, 8'h54);
    step(4'h1, 2'h1);
    step(4'h0, 2'h1);
    apb(1'b1, RIPS_ADDR_PRIO, 8'h00);
    step(4'h2, 2'h0);
    apb(1'b1, RIPS_ADDR_IRQ_CLR, 8'h0F);
    apb(1'b1, RIPS_ADDR_IRQ_EN, 8'h08);
    step(4'h0, 2'h0);
    chk("irq idle", 32'h0, {31'h0, irq});
    step(4'hF, 2'h0);
    chk("irq set", 32'h1, {31'h0, irq});
    apb(1'b0, RIPS_ADDR_IRQ_STAT, 8'h0);
    chk("irq stat", 32'h1, {31'h0, rd[RIPS_EV_NOREF]});
    apb(1'b1, RIPS_ADDR_IRQ_EN, 8'h00);
    step(4'hF, 2'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, RIPS_ADDR_IRQ_EN, 8'h08);
    step(4'h0, 2'h0);
    apb(1'b1, RIPS_ADDR_IRQ_CLR, 8'h08);
    step(4'h0, 2'h0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    complete_run();
  end
endmodule
